// ==== rtl/smrl_consts.svh ====
// Contract
// R1: Monitor control powers up as 0x5A, enabled.
// R2: Control 0xA5 disables the low-supply reset.
// R3: Undefined control code resets device, reloads 0x5A.
// R4: Undefined code reset sets corruption flag bit1.
// R5: Enabled low supply resets and sets brownout.
// R6: Low supply shorter than filter time ignored.
// R7: Brownout reset keeps the control register.
// R8: Low-supply reset off in sleep or idle.
// R9: Brownout flag bit2, software clears only.
// R10: Cause register bits 7 to 4 read zero.
// R11: Active watchdog time-out resets, sets time-out.
// R12: Low-power time-out clears PC, SP, sets flags.
// R13: Time-out and power-down flags per reset type.
// R14: Power-on clears watchdog, interrupts, timers.
// R15: Power-on zeroes PC, stack to top.
// R16: Ports preset all ones on full resets.
// R17: Cause flags persist until software writes zero.
`ifndef SMRL_CONSTS_SVH
`define SMRL_CONSTS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define SMRL_ADDR_CTRL      8'h00
`define SMRL_ADDR_CAUSE     8'h04
`define SMRL_ADDR_CORE      8'h08
`define SMRL_ADDR_EVT_STAT  8'h0C
`define SMRL_ADDR_EVT_MASK  8'h10

// ------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------
`define SMRL_CODE_ENABLE    8'h5A
`define SMRL_CODE_DISABLE   8'hA5
`define SMRL_PORT_PRESET    8'hFF
`define SMRL_CAUSE_BROWNOUT 2
`define SMRL_CAUSE_MONITOR  1
`define SMRL_CORE_TO        0
`define SMRL_CORE_PDF       1

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SMRL_PCLK_NS        50
`define SMRL_BROWNOUT_FILTER_TIME_NS        120000
`define SMRL_CORRUPTION_RESET_DELAY_NS     100000
`define SMRL_HOLD_NS        800
`define SMRL_BROWNOUT_FILTER_TIME_CYC       ((`SMRL_BROWNOUT_FILTER_TIME_NS + `SMRL_PCLK_NS - 1) / `SMRL_PCLK_NS)
`define SMRL_CORRUPTION_RESET_DELAY_CYC    ((`SMRL_CORRUPTION_RESET_DELAY_NS + `SMRL_PCLK_NS - 1) / `SMRL_PCLK_NS)
`define SMRL_HOLD_CYC       ((`SMRL_HOLD_NS + `SMRL_PCLK_NS - 1) / `SMRL_PCLK_NS)

`endif

// ==== rtl/smrl_pkg.sv ====
package smrl_pkg;

   typedef struct packed {
      logic reset_ctrl_corrupt_flag;
      logic brownout_flag;
      logic monitor_ctrl_corrupt_flag;
      logic watchdog_ctrl_corrupt_flag;
   } smrl_cause_type;

   typedef struct packed {
      logic wdt_wake;
      logic wdt_reset;
      logic corrupt_reset;
      logic brownout_reset;
   } smrl_event_type;

   typedef enum logic [1:0] {
      SEQ_POR,
      SEQ_RUN,
      SEQ_HOLD
   } smrl_seq_type;

endpackage

// ==== rtl/smrl_top.sv ====
`timescale 1ns/1ps
`include "smrl_consts.svh"

module smrl_top #(
   parameter int unsigned CNT_W        = 16,
   parameter int unsigned BROWNOUT_CYC = `SMRL_BROWNOUT_FILTER_TIME_CYC,
   parameter int unsigned CORRUPT_CYC  = `SMRL_CORRUPTION_RESET_DELAY_CYC,
   parameter int unsigned HOLD_CYC     = `SMRL_HOLD_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        supply_low,
   input  wire logic        low_power_mode,
   input  wire logic        wdt_timeout,
   input  wire logic        wdt_ctrl_corrupt,
   input  wire logic        reset_ctrl_corrupt,
   output logic             core_reset,
   output logic             por_init,
   output logic             pc_sp_clear,
   output logic             port_preset,
   output logic [7:0]       port_preset_value,
   output logic             watchdog_timeout_flag,
   output logic             powerdown_flag,
   output logic             irq
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [7:0]                 supply_monitor_control_reg;
   smrl_pkg::smrl_cause_type   reset_cause_flags_reg;
   smrl_pkg::smrl_event_type   evt_stat_reg;
   smrl_pkg::smrl_event_type   evt_mask_reg;
   smrl_pkg::smrl_event_type   evt_set;
   smrl_pkg::smrl_seq_type     seq_reg;
   logic [CNT_W-1:0]           brown_cnt_reg;
   logic [CNT_W-1:0]           corrupt_cnt_reg;
   logic [CNT_W-1:0]           hold_cnt_reg;
   logic                       wake_pulse_reg;
   logic                       first_cyc_reg;
   logic [31:0]                prdata_reg;
   logic                       running;
   logic                       wr_en;
   logic                       rd_setup;
   logic                       mapped;
   logic                       brown_cond;
   logic                       brown_fire;
   logic                       code_bad;
   logic                       corrupt_fire;
   logic                       wdt_active;
   logic                       wdt_lowpow;
   logic                       full_req;
   logic                       wr_ctrl;
   logic [3:0]                 cause_set;
   logic [3:0]                 cause_keep;
   logic [3:0]                 evt_keep;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign pready   = 1'b1;
   assign mapped   = (paddr == `SMRL_ADDR_CTRL) || (paddr == `SMRL_ADDR_CAUSE) ||
                     (paddr == `SMRL_ADDR_CORE) || (paddr == `SMRL_ADDR_EVT_STAT) ||
                     (paddr == `SMRL_ADDR_EVT_MASK);
   assign pslverr  = psel && penable && !mapped;
   assign wr_en    = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign wr_ctrl  = wr_en && (paddr == `SMRL_ADDR_CTRL);
   assign prdata   = prdata_reg;

   // Read data captured in setup so it comes from a flop in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr)
            `SMRL_ADDR_CTRL:     prdata_reg <= {24'h00_0000, supply_monitor_control_reg};
            `SMRL_ADDR_CAUSE:    prdata_reg <= {28'h000_0000, reset_cause_flags_reg}; // R10
            `SMRL_ADDR_CORE:     prdata_reg <= {30'h0000_0000, powerdown_flag, watchdog_timeout_flag};
            `SMRL_ADDR_EVT_STAT: prdata_reg <= {28'h000_0000, evt_stat_reg};
            `SMRL_ADDR_EVT_MASK: prdata_reg <= {28'h000_0000, evt_mask_reg};
            default:             prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Supply monitor control
   // ------------------------------------------------------------
   // Corruption reload beats a same-cycle software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_monitor_control_reg <= `SMRL_CODE_ENABLE; // R1
      end else if (corrupt_fire) begin
         supply_monitor_control_reg <= `SMRL_CODE_ENABLE; // R3
      end else if (wr_ctrl) begin
         supply_monitor_control_reg <= pwdata[7:0];
      end
   end

   assign code_bad = (supply_monitor_control_reg != `SMRL_CODE_ENABLE) &&
                     (supply_monitor_control_reg != `SMRL_CODE_DISABLE); // R3

   // Delay restarts if software restores a valid code in time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         corrupt_cnt_reg <= '0;
      end else if (!code_bad || !running) begin
         corrupt_cnt_reg <= '0;
      end else if (!corrupt_fire) begin
         corrupt_cnt_reg <= corrupt_cnt_reg + CNT_W'(1);
      end
   end

   assign corrupt_fire = running && code_bad && (corrupt_cnt_reg == CNT_W'(CORRUPT_CYC - 1)); // R3

   // ------------------------------------------------------------
   // Brownout filter
   // ------------------------------------------------------------
   // Comparator assumed to flag only the 0.9V to threshold band
   assign brown_cond = running && supply_low && !low_power_mode &&
                       (supply_monitor_control_reg == `SMRL_CODE_ENABLE); // R2 R5 R8

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brown_cnt_reg <= '0;
      end else if (!brown_cond) begin
         brown_cnt_reg <= '0; // R6
      end else if (!brown_fire) begin
         brown_cnt_reg <= brown_cnt_reg + CNT_W'(1);
      end
   end

   // Fires only once the low level has outlasted the filter time
   assign brown_fire = brown_cond && (brown_cnt_reg == CNT_W'(BROWNOUT_CYC)); // R6

   // ------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------
   assign running    = (seq_reg == smrl_pkg::SEQ_RUN);
   assign wdt_active = running && wdt_timeout && !low_power_mode; // R11
   assign wdt_lowpow = running && wdt_timeout && low_power_mode;  // R12
   assign full_req   = brown_fire || corrupt_fire || wdt_active ||
                       (running && (wdt_ctrl_corrupt || reset_ctrl_corrupt));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_reg      <= smrl_pkg::SEQ_POR;
         hold_cnt_reg <= '0;
      end else begin
         case (seq_reg)
            smrl_pkg::SEQ_POR,
            smrl_pkg::SEQ_HOLD: begin
               if (hold_cnt_reg == CNT_W'(HOLD_CYC - 1)) begin
                  seq_reg      <= smrl_pkg::SEQ_RUN;
                  hold_cnt_reg <= '0;
               end else begin
                  hold_cnt_reg <= hold_cnt_reg + CNT_W'(1);
               end
            end
            smrl_pkg::SEQ_RUN: begin
               if (full_req) begin
                  seq_reg <= smrl_pkg::SEQ_HOLD; // R5 R11
               end
               hold_cnt_reg <= '0;
            end
            default: begin
               seq_reg      <= smrl_pkg::SEQ_POR;
               hold_cnt_reg <= '0;
            end
         endcase
      end
   end

   // Low-power wake touches only PC and SP, never the full reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_pulse_reg <= 1'b0;
      end else begin
         wake_pulse_reg <= wdt_lowpow; // R12
      end
   end

   assign core_reset        = !running;
   assign por_init          = (seq_reg == smrl_pkg::SEQ_POR);  // R14
   assign pc_sp_clear       = core_reset || wake_pulse_reg;    // R15 R12
   assign port_preset       = core_reset;                      // R16
   assign port_preset_value = `SMRL_PORT_PRESET;               // R16

   // ------------------------------------------------------------
   // Reset cause flags
   // ------------------------------------------------------------
   // Writes can only clear; a set in the same cycle still wins
   assign cause_set  = {reset_ctrl_corrupt && running, brown_fire, corrupt_fire,
                        wdt_ctrl_corrupt && running};          // R4 R9
   assign cause_keep = (wr_en && (paddr == `SMRL_ADDR_CAUSE)) ? pwdata[3:0] : 4'hF;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_cause_flags_reg <= '0;
      end else begin
         reset_cause_flags_reg <= smrl_pkg::smrl_cause_type'(cause_set |
                                  (reset_cause_flags_reg & cause_keep)); // R17
      end
   end

   // ------------------------------------------------------------
   // Time-out and power-down flags
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_timeout_flag <= 1'b0; // R13
         powerdown_flag        <= 1'b0; // R13
      end else begin
         if (wdt_active || wdt_lowpow) begin
            watchdog_timeout_flag <= 1'b1; // R11 R13
         end else if (wr_en && (paddr == `SMRL_ADDR_CORE) && !pwdata[`SMRL_CORE_TO]) begin
            watchdog_timeout_flag <= 1'b0;
         end
         if (wdt_lowpow) begin
            powerdown_flag <= 1'b1; // R13
         end else if (wr_en && (paddr == `SMRL_ADDR_CORE) && !pwdata[`SMRL_CORE_PDF]) begin
            powerdown_flag <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt events
   // ------------------------------------------------------------
   assign evt_set  = '{wdt_wake: wdt_lowpow, wdt_reset: wdt_active,
                       corrupt_reset: corrupt_fire, brownout_reset: brown_fire};
   assign evt_keep = (wr_en && (paddr == `SMRL_ADDR_EVT_STAT)) ? ~pwdata[3:0] : 4'hF;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_stat_reg <= '0;
      end else begin
         evt_stat_reg <= smrl_pkg::smrl_event_type'(evt_set | (evt_stat_reg & evt_keep));
      end
   end

   // Mask clears on power-on so every interrupt starts disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_mask_reg <= '0; // R14
      end else if (wr_en && (paddr == `SMRL_ADDR_EVT_MASK)) begin
         evt_mask_reg <= smrl_pkg::smrl_event_type'(pwdata[3:0]);
      end
   end

   assign irq = |(evt_stat_reg & evt_mask_reg);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_cyc_reg <= 1'b1;
      end else begin
         first_cyc_reg <= 1'b0;
      end
   end

   sequence s_wdt_lowpow;
      wdt_lowpow;
   endsequence

   sequence s_wake_done;
      pc_sp_clear && watchdog_timeout_flag && powerdown_flag && running;
   endsequence

   property p_ctrl_por;
      @(posedge pclk) disable iff (!presetn) first_cyc_reg |-> supply_monitor_control_reg == `SMRL_CODE_ENABLE;
   endproperty
   a_ctrl_por: assert property (p_ctrl_por) else $error("control not 0x5A after power-on"); // R1

   property p_disable_code;
      @(posedge pclk) disable iff (!presetn)
         supply_monitor_control_reg == `SMRL_CODE_DISABLE |-> !brown_fire && !corrupt_fire;
   endproperty
   a_disable_code: assert property (p_disable_code) else $error("reset while monitor disabled"); // R2

   property p_corrupt_reload;
      @(posedge pclk) disable iff (!presetn)
         corrupt_fire |=> supply_monitor_control_reg == `SMRL_CODE_ENABLE && seq_reg == smrl_pkg::SEQ_HOLD;
   endproperty
   a_corrupt_reload: assert property (p_corrupt_reload) else $error("corruption reset missing"); // R3

   property p_corrupt_flag;
      @(posedge pclk) disable iff (!presetn) corrupt_fire |=> reset_cause_flags_reg.monitor_ctrl_corrupt_flag;
   endproperty
   a_corrupt_flag: assert property (p_corrupt_flag) else $error("corruption flag not set"); // R4

   property p_filter;
      @(posedge pclk) disable iff (!presetn) !brown_cond ##1 brown_cond |-> !brown_fire;
   endproperty
   a_filter: assert property (p_filter) else $error("brownout fired without filter time"); // R6

   // Own run length, so the check does not lean on the filter counter
   logic [CNT_W-1:0]           low_run_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_run_reg <= '0;
      end else if (!brown_cond) begin
         low_run_reg <= '0;
      end else if (low_run_reg != '1) begin
         low_run_reg <= low_run_reg + CNT_W'(1);
      end
   end

   property p_filter_len;
      @(posedge pclk) disable iff (!presetn) brown_fire |-> low_run_reg >= CNT_W'(BROWNOUT_CYC);
   endproperty
   a_filter_len: assert property (p_filter_len) else $error("brownout before filter time ran out"); // R6

   property p_full_ports;
      @(posedge pclk) disable iff (!presetn)
         core_reset |-> port_preset && pc_sp_clear && port_preset_value == `SMRL_PORT_PRESET;
   endproperty
   a_full_ports: assert property (p_full_ports) else $error("ports not preset during full reset"); // R16

   property p_por_irq_off;
      @(posedge pclk) disable iff (!presetn) first_cyc_reg |-> evt_mask_reg == '0 && por_init && !irq;
   endproperty
   a_por_irq_off: assert property (p_por_irq_off) else $error("interrupts not off after power-on"); // R14

   property p_wake_no_reset;
      @(posedge pclk) disable iff (!presetn) s_wdt_lowpow |=> !core_reset && !port_preset;
   endproperty
   a_wake_no_reset: assert property (p_wake_no_reset) else $error("low-power wake caused full reset"); // R12

   property p_brown_keep;
      @(posedge pclk) disable iff (!presetn) brown_fire && !wr_ctrl |=> $stable(supply_monitor_control_reg);
   endproperty
   a_brown_keep: assert property (p_brown_keep) else $error("brownout changed control"); // R7

   property p_lowpow_off;
      @(posedge pclk) disable iff (!presetn) low_power_mode |-> !brown_fire;
   endproperty
   a_lowpow_off: assert property (p_lowpow_off) else $error("brownout in low power"); // R8

   property p_brown_flag;
      @(posedge pclk) disable iff (!presetn) brown_fire |=> reset_cause_flags_reg.brownout_flag && core_reset;
   endproperty
   a_brown_flag: assert property (p_brown_flag) else $error("brownout flag or reset missing"); // R9

   property p_cause_upper;
      @(posedge pclk) disable iff (!presetn)
         psel && penable && !pwrite && paddr == `SMRL_ADDR_CAUSE |-> prdata[31:4] == 28'h000_0000;
   endproperty
   a_cause_upper: assert property (p_cause_upper) else $error("cause upper bits not zero"); // R10

   property p_wdt_active;
      @(posedge pclk) disable iff (!presetn) wdt_active |=> watchdog_timeout_flag && core_reset && port_preset;
   endproperty
   a_wdt_active: assert property (p_wdt_active) else $error("active time-out reset wrong"); // R11

   property p_wdt_wake;
      @(posedge pclk) disable iff (!presetn) s_wdt_lowpow |=> s_wake_done ##1 !pc_sp_clear;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("low-power wake wrong"); // R12

   property p_por_flags;
      @(posedge pclk) disable iff (!presetn) first_cyc_reg |-> !watchdog_timeout_flag && !powerdown_flag && por_init;
   endproperty
   a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong"); // R13

endmodule

// ==== dv/supply_monitor_reset_logic_test.sv ====
`timescale 1ns/1ps
`include "smrl_consts.svh"

module supply_monitor_reset_logic_test;
   // ------------------------------------------------------------
   // Short counts keep the run small
   // ------------------------------------------------------------
   localparam int BRN  = 4;
   localparam int COR  = 6;
   localparam int HOLD = 3;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pready, pslverr, core_reset, por_init, pc_sp_clear, port_preset, irq;
   logic        watchdog_timeout_flag, powerdown_flag;
   logic [31:0] prdata;
   logic [7:0]  port_preset_value;
   logic        supply_low = 1'b0;
   logic        low_power_mode = 1'b0;
   logic [2:0]  pulse_in = 3'h0;
   int          fails = 0;
   int          n_compared = 0;
   int          ctrl_m, cause_m, core_m, evt_m, n;
   logic [15:0] lfsr_reg = 16'h1712;
   logic [31:0] d;
   logic        e, sp, cr;
   logic [7:0]  code;

   smrl_top #(.BROWNOUT_CYC(BRN), .CORRUPT_CYC(COR), .HOLD_CYC(HOLD)) i_smrl_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .supply_low(supply_low), .low_power_mode(low_power_mode), .wdt_timeout(pulse_in[0]),
      .wdt_ctrl_corrupt(pulse_in[1]), .reset_ctrl_corrupt(pulse_in[2]),
      .core_reset(core_reset), .por_init(por_init), .pc_sp_clear(pc_sp_clear),
      .port_preset(port_preset), .port_preset_value(port_preset_value),
      .watchdog_timeout_flag(watchdog_timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq));

   initial begin
      forever #25 pclk = ~pclk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (exp !== got) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Waits for pready however long it takes; the watchdog cuts a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input string what, input int exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, d);
   endtask

   task automatic rd_all;
      rd(`SMRL_ADDR_CTRL, "control", ctrl_m);
      rd(`SMRL_ADDR_CAUSE, "cause", cause_m);
      rd(`SMRL_ADDR_CORE, "core status", core_m);
      chk("timeout flag", core_m & 1, {31'h0, watchdog_timeout_flag});
      chk("powerdown flag", (core_m >> 1) & 1, {31'h0, powerdown_flag});
   endtask

   task automatic wait_cr(input logic lvl, input int lim);
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (core_reset !== lvl && n < lim);
   endtask

   task automatic watch(input int k);
      sp = 1'b0;
      cr = 1'b0;
      repeat (k) begin
         #1;
         sp |= pc_sp_clear;
         cr |= core_reset | port_preset;
         @(posedge pclk);
      end
   endtask

   // Full reset other than power-on: ports preset, power-on init quiet
   task automatic full_reset(input int lim);
      wait_cr(1'b1, lim);
      chk("full reset", 1, {31'h0, core_reset});
      chk("port preset", 32'h1FF, {23'h0, port_preset, port_preset_value});
      chk("pc clear", 1, {31'h0, pc_sp_clear});
      chk("no power-on init", 0, {31'h0, por_init});
      wait_cr(1'b0, HOLD + 4);
   endtask

   task automatic pulse(input int i);
      @(posedge pclk);
      pulse_in[i] <= 1'b1;
      @(posedge pclk);
      pulse_in[i] <= 1'b0;
   endtask

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      $display("unexpected watchdog expiry: expected done, seen hang");
      test_done();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      ctrl_m = 8'h5A;
      cause_m = 0;
      core_m = 0;
      evt_m = 0;
      repeat (4) @(posedge pclk);
      chk("reset outputs", 32'hF, {28'h0, core_reset, por_init, pc_sp_clear, port_preset});
      presetn <= 1'b1;
      wait_cr(1'b0, HOLD + 4);
      chk("por init done", 0, {31'h0, por_init});
      rd_all();
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 0, d);
      $display("done: power-on");
      @(posedge pclk);
      supply_low <= 1'b1;
      repeat (BRN) @(posedge pclk);
      supply_low <= 1'b0;
      watch(12);
      chk("short low supply", 0, {31'h0, cr});
      @(posedge pclk);
      supply_low <= 1'b1;
      wait_cr(1'b1, BRN + 6);
      chk("filter length", 1, {31'h0, n > BRN});
      @(posedge pclk);
      supply_low <= 1'b0;
      wait_cr(1'b0, HOLD + 4);
      cause_m |= 4;
      evt_m |= 1;
      rd_all();
      $display("done: brownout");
      @(posedge pclk);
      supply_low <= 1'b1;
      low_power_mode <= 1'b1;
      watch(3 * BRN);
      chk("low power ignores supply", 0, {31'h0, cr});
      low_power_mode <= 1'b0;
      apb(1'b1, `SMRL_ADDR_CTRL, 32'hA5);
      ctrl_m = 8'hA5;
      watch(3 * BRN);
      chk("disabled ignores supply", 0, {31'h0, cr});
      supply_low <= 1'b0;
      rd_all();
      apb(1'b1, `SMRL_ADDR_CTRL, 32'h5A);
      ctrl_m = 8'h5A;
      apb(1'b1, `SMRL_ADDR_CAUSE, 32'hFF);
      rd_all();
      apb(1'b1, `SMRL_ADDR_CAUSE, 32'h0);
      cause_m = 0;
      apb(1'b1, `SMRL_ADDR_CAUSE, 32'hFF);
      rd_all();
      $display("done: disable and clear");
      for (int t = 0; t < 2; t++) begin
         lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
         code = lfsr_reg[7:0];
         if (code == 8'h5A || code == 8'hA5) code ^= 8'h01;
         apb(1'b1, `SMRL_ADDR_CTRL, {24'h0, code});
         if (t == 0) begin
            apb(1'b1, `SMRL_ADDR_CTRL, 32'h5A);
            watch(COR + 6);
            chk("corruption cancelled", 0, {31'h0, cr});
         end else begin
            full_reset(COR + 6);
         end
      end
      cause_m |= 2;
      evt_m |= 2;
      rd_all();
      $display("done: corruption");
      pulse(0);
      full_reset(6);
      core_m |= 1;
      evt_m |= 4;
      rd_all();
      @(posedge pclk);
      low_power_mode <= 1'b1;
      pulse(0);
      watch(6);
      chk("wake pc clear", 1, {31'h0, sp});
      chk("wake no full reset", 0, {31'h0, cr});
      low_power_mode <= 1'b0;
      core_m |= 3;
      evt_m |= 8;
      rd_all();
      $display("done: watchdog");
      rd(`SMRL_ADDR_EVT_STAT, "event status", evt_m);
      chk("irq masked", 0, {31'h0, irq});
      apb(1'b1, `SMRL_ADDR_EVT_MASK, 32'h4);
      #1 chk("irq raised", 1, {31'h0, irq});
      apb(1'b1, `SMRL_ADDR_EVT_STAT, 32'h4);
      #1 chk("irq cleared", 0, {31'h0, irq});
      apb(1'b1, `SMRL_ADDR_EVT_MASK, 32'hF);
      #1 chk("irq others", 1, {31'h0, irq});
      apb(1'b1, `SMRL_ADDR_EVT_STAT, 32'hF);
      rd(`SMRL_ADDR_EVT_STAT, "event status clear", 0);
      $display("done: interrupt");
      for (int i = 1; i < 3; i++) begin
         pulse(i);
         full_reset(6);
      end
      cause_m |= 9;
      rd_all();
      apb(1'b1, `SMRL_ADDR_CTRL, 32'hA5);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("second power-on", 32'hF, {28'h0, core_reset, por_init, pc_sp_clear, port_preset});
      presetn <= 1'b1;
      wait_cr(1'b0, HOLD + 4);
      ctrl_m = 8'h5A;
      cause_m = 0;
      core_m = 0;
      rd_all();
      $display("done: second power-on");
      test_done();
   end
endmodule
